// ### inc/irq_dma_pkg.sv
// constants, field layout and carrier types for the interrupt status and dma burst block
package irq_dma_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register bus
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam logic [11:0] STATUS_OFFSET   = 12'h218;
    localparam logic [11:0] MASK_OFFSET     = 12'h21c;
    localparam logic [11:0] BURST_OFFSET    = 12'h264;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status layout
    localparam logic [31:0] STATUS_RESET    = 32'h00000000;
    localparam logic [31:0] STATUS_VALID    = 32'h03fffdff;
    localparam logic [31:0] MASK_RESET      = 32'h03fffdff;
    localparam int          BIT_BUS_RESET   = 0;
    localparam int          BIT_SOF         = 1;
    localparam int          BIT_PSEUDO_FRAME_TICK_FLAG        = 2;
    localparam int          BIT_SUSPEND     = 3;
    localparam int          BIT_RESUME      = 4;
    localparam int          BIT_HS_CHANGE   = 5;
    localparam int          BIT_DMA         = 6;
    localparam int          BIT_VBUS        = 7;
    localparam int          BIT_EP0_SETUP   = 8;
    localparam int          BIT_EP_BASE     = 10;
    localparam int          NUM_EP          = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // burst length layout
    localparam int          BURST_W         = 13;
    localparam logic [12:0] BURST_RESET     = 13'h0004;
    localparam logic [12:0] BYTES_BUS16     = 13'h0002;
    localparam logic [12:0] BYTES_BUS32     = 13'h0004;
    localparam int          DMA_REASON_W    = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // pseudo frame tick timing
    localparam int          CLK_FREQ_MHZ    = 25;
    localparam int          PSEUDO_FRAME_TICK_FLAG_FS_US      = 1000;
    localparam int          PSEUDO_FRAME_TICK_FLAG_HS_US      = 125;
    localparam int          PSEUDO_FRAME_TICK_FLAG_FS_CYCLES  = PSEUDO_FRAME_TICK_FLAG_FS_US * CLK_FREQ_MHZ;
    localparam int          PSEUDO_FRAME_TICK_FLAG_HS_CYCLES  = PSEUDO_FRAME_TICK_FLAG_HS_US * CLK_FREQ_MHZ;
    localparam int          TICK_CNT_W      = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [7:0] epTx;        // endpoint_tx_flag events, endpoint 7 down to 0
        logic [7:0] epRx;        // endpoint_rx_flag events
        logic       epZeroSetup;
        logic       vbusRise;
        logic       resume;
        logic       suspend;
        logic       sof;
        logic       busReset;
    } usb_events_t;

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] mask;
        logic [12:0] burst;
        logic [31:0] rdData;
        logic        intOut;
        logic        highSpeedPrev;
        logic [15:0] dmaReasonPrev;
    } irq_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } tick_state_t;

    typedef struct packed {
        logic [12:0] byteCnt;
        logic        req;
    } pace_state_t;

endpackage

// ### src/pseudo_frame_ticker.sv
// free running pseudo frame tick, period chosen by bus speed
`timescale 1ns/10ps
module pseudo_frame_ticker
    import irq_dma_pkg::*;
#(
    parameter logic [15:0] FS_CYCLES = 16'(PSEUDO_FRAME_TICK_FLAG_FS_CYCLES),
    parameter logic [15:0] HS_CYCLES = 16'(PSEUDO_FRAME_TICK_FLAG_HS_CYCLES)
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    input  wire logic highSpeed,
    output logic      tick
);

    tick_state_t stateReg;
    tick_state_t stateNext;
    logic [15:0] periodLast;

    ////////////////////////////////////////////////////////////////////////////////
    // count to the period for the present speed, not locked to bus frames
    always_comb begin
        stateNext  = stateReg;
        periodLast = highSpeed ? HS_CYCLES - 16'h0001 : FS_CYCLES - 16'h0001;
        stateNext.tick = 1'b0;
        if (stateReg.cnt >= periodLast) begin
            stateNext.cnt  = 16'h0000;
            stateNext.tick = 1'b1;
        end else begin
            stateNext.cnt = stateReg.cnt + 16'h0001;
        end
    end

    // state register with clock enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateReg <= '0;
        end else if (clkEn) begin
            stateReg <= stateNext;
        end
    end

    assign tick = stateReg.tick;

endmodule

// ### src/dma_request_pacer.sv
// paces the dma request line by the programmed burst length
`timescale 1ns/10ps
module dma_request_pacer
    import irq_dma_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        dmaPending,
    input  wire logic        dmaCycleDone,
    input  wire logic        busWide32,
    input  wire logic        busReset,
    input  wire logic [12:0] burstLength,
    output logic             dmaRequest
);

    pace_state_t stateReg;
    pace_state_t stateNext;
    logic [13:0] bytesAfter;

    ////////////////////////////////////////////////////////////////////////////////
    // count bytes moved; drop the request for one cycle at each burst end
    always_comb begin
        stateNext  = stateReg;
        bytesAfter = {1'b0, stateReg.byteCnt}
                   + {1'b0, (busWide32 ? BYTES_BUS32 : BYTES_BUS16)};
        if (busReset) begin
            stateNext = '0;
        end else if (stateReg.req) begin
            if (dmaCycleDone) begin
                if (bytesAfter >= {1'b0, burstLength}) begin
                    stateNext.req     = 1'b0;
                    stateNext.byteCnt = 13'h0000;
                end else begin
                    stateNext.byteCnt = bytesAfter[12:0];
                end
            end else if (!dmaPending) begin
                // a burst cut short must not leave its bytes for the next one
                stateNext.req     = 1'b0;
                stateNext.byteCnt = 13'h0000;
            end
        end else begin
            stateNext.req = dmaPending;
        end
    end

    // state register with clock enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateReg <= '0;
        end else if (clkEn) begin
            stateReg <= stateNext;
        end
    end

    assign dmaRequest = stateReg.req;

endmodule

// ### src/peripheral_irq_and_dma_burst.sv
// peripheral interrupt status register, mask, burst length and dma request pacing
`timescale 1ns/10ps
module peripheral_irq_and_dma_burst
    import irq_dma_pkg::*;
#(
    parameter logic [15:0] PSEUDO_FRAME_TICK_FLAG_FS_COUNT = 16'(PSEUDO_FRAME_TICK_FLAG_FS_CYCLES)
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    clkEn,
    // register port
    input  wire logic [ADDR_W-1:0]       regAddr,
    input  wire logic [DATA_W-1:0]       regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output logic      [DATA_W-1:0]       regRdData,
    // usb core events, one cycle pulses on this clock
    input  wire usb_events_t             usbEvents,
    input  wire logic                    highSpeed,
    input  wire logic [DMA_REASON_W-1:0] dmaReason,
    // dma transfer side
    input  wire logic                    dmaPending,
    input  wire logic                    dmaCycleDone,
    input  wire logic                    busWide32,
    output logic                         dmaRequest,
    // interrupt
    output logic                         interruptOut
);

    irq_state_t  stateReg;
    irq_state_t  stateNext;
    logic        pseudoTick;
    logic [31:0] eventVector;
    logic [31:0] clearVector;
    logic        statusWrite;
    logic        maskWrite;
    logic        burstWrite;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // true when the strobe is present and the address hits the offset
    function automatic logic reg_hit(input logic strobe,
                                     input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] offset);
        reg_hit = strobe && (addr == offset);
    endfunction

    // places every hardware event at its status bit position
    function automatic logic [31:0] build_events(input usb_events_t ev,
                                                 input logic pseudo_frame_tick_flag,
                                                 input logic hsEntry,
                                                 input logic dmaChange);
        logic [31:0] v;
        v = 32'h00000000;
        for (int i = 0; i < NUM_EP; i++) begin
            v[BIT_EP_BASE + 2*i]     = ev.epRx[i];
            v[BIT_EP_BASE + 2*i + 1] = ev.epTx[i];
        end
        v[BIT_EP0_SETUP] = ev.epZeroSetup;
        v[BIT_VBUS]      = ev.vbusRise;
        v[BIT_DMA]       = dmaChange;
        v[BIT_HS_CHANGE] = hsEntry;
        v[BIT_RESUME]    = ev.resume;
        v[BIT_SUSPEND]   = ev.suspend;
        v[BIT_PSEUDO_FRAME_TICK_FLAG]      = pseudo_frame_tick_flag;
        v[BIT_SOF]       = ev.sof;
        v[BIT_BUS_RESET] = ev.busReset;
        build_events = v & STATUS_VALID;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pseudo frame tick source
    pseudo_frame_ticker #(
        .FS_CYCLES (PSEUDO_FRAME_TICK_FLAG_FS_COUNT),
        .HS_CYCLES (16'(PSEUDO_FRAME_TICK_FLAG_HS_CYCLES))
    ) ticker (
        .clk       (clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .highSpeed (highSpeed),
        .tick      (pseudoTick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // dma request pacing by the burst length register
    dma_request_pacer pacer (
        .clk          (clk),
        .rst_n        (rst_n),
        .clkEn        (clkEn),
        .dmaPending   (dmaPending),
        .dmaCycleDone (dmaCycleDone),
        .busWide32    (busWide32),
        .busReset     (usbEvents.busReset),
        .burstLength  (stateReg.burst),
        .dmaRequest   (dmaRequest)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // address decode and event gathering
    always_comb begin
        statusWrite = reg_hit(regWr, regAddr, STATUS_OFFSET);
        maskWrite   = reg_hit(regWr, regAddr, MASK_OFFSET);
        burstWrite  = reg_hit(regWr, regAddr, BURST_OFFSET);
        clearVector = statusWrite ? (regWrData & STATUS_VALID) : 32'h00000000;
        eventVector = build_events(usbEvents,
                                   pseudoTick,
                                   highSpeed && !stateReg.highSpeedPrev,
                                   dmaReason != stateReg.dmaReasonPrev);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state: status, mask, burst, read data and interrupt level
    always_comb begin
        stateNext = stateReg;

        // edge trackers for speed change and dma reason content
        stateNext.highSpeedPrev = highSpeed;
        stateNext.dmaReasonPrev = dmaReason;

        // write one clears; a new event in the same cycle still sets the bit
        stateNext.status = (stateReg.status & ~clearVector) | eventVector;

        // bus reset leaves only its own flag standing
        if (usbEvents.busReset) begin
            stateNext.status = 32'h00000001 << BIT_BUS_RESET;
        end

        // mask of the same layout, unused bits kept at zero
        if (maskWrite) begin
            stateNext.mask = regWrData & STATUS_VALID;
        end

        // burst length: 13 stored bits, reserved bits not kept
        if (usbEvents.busReset) begin
            stateNext.burst = BURST_RESET;
        end else if (burstWrite) begin
            stateNext.burst = regWrData[BURST_W-1:0];
        end

        // read data valid the cycle after the read strobe only
        stateNext.rdData = 32'h00000000;
        if (regRd) begin
            case (regAddr)
                STATUS_OFFSET: begin
                    stateNext.rdData = stateReg.status;
                end
                MASK_OFFSET: begin
                    stateNext.rdData = stateReg.mask;
                end
                BURST_OFFSET: begin
                    stateNext.rdData = {19'h00000, stateReg.burst};
                end
                default: begin
                    stateNext.rdData = 32'h00000000;
                end
            endcase
        end

        // level interrupt while any unmasked status bit is set
        stateNext.intOut = |(stateNext.status & stateNext.mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register with synchronous reset and clock enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateReg.status        <= STATUS_RESET;
            stateReg.mask          <= MASK_RESET;
            stateReg.burst         <= BURST_RESET;
            stateReg.rdData        <= 32'h00000000;
            stateReg.intOut        <= 1'b0;
            stateReg.highSpeedPrev <= 1'b0;
            stateReg.dmaReasonPrev <= 16'h0000;
        end else if (clkEn) begin
            stateReg <= stateNext;
        end
    end

    // outputs straight from flip-flops
    assign regRdData    = stateReg.rdData;
    assign interruptOut = stateReg.intOut;

endmodule

// ### tb/irq_dma_chk.sv
// concurrent checks on the ports of the interrupt status and dma burst block
`timescale 1ns/10ps
module irq_dma_chk
    import irq_dma_pkg::*;
#(
    parameter logic [15:0] PSEUDO_FRAME_TICK_FLAG_FS_COUNT = 16'(PSEUDO_FRAME_TICK_FLAG_FS_CYCLES)
) (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    clkEn,
    input wire logic [ADDR_W-1:0]       regAddr,
    input wire logic [DATA_W-1:0]       regWrData,
    input wire logic                    regWr,
    input wire logic                    regRd,
    input wire logic [DATA_W-1:0]       regRdData,
    input wire usb_events_t             usbEvents,
    input wire logic                    highSpeed,
    input wire logic [DMA_REASON_W-1:0] dmaReason,
    input wire logic                    dmaPending,
    input wire logic                    dmaCycleDone,
    input wire logic                    busWide32,
    input wire logic                    dmaRequest,
    input wire logic                    interruptOut
);
    logic [31:0] maskReg;
    logic [12:0] burstReg;

    // shadow of mask and burst length as software left them
    always_ff @(posedge clk) begin
        if (clkEn && !rst_n) begin
            maskReg  <= MASK_RESET;
            burstReg <= BURST_RESET;
        end else if (clkEn) begin
            if (regWr && regAddr == MASK_OFFSET) maskReg <= regWrData;
            if (usbEvents.busReset) burstReg <= BURST_RESET;
            else if (regWr && regAddr == BURST_OFFSET) burstReg <= regWrData[12:0];
        end
    end

    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // readback carries the stored length, upper bits zero
    property p_burst_back;
        logic [12:0] b;
        (clkEn && regRd && regAddr == BURST_OFFSET && !usbEvents.busReset, b = burstReg)
            |=> regRdData == {19'h0, b};
    endproperty

    a_read_one_cycle: assert property (
        (clkEn && regRd) ##1 (clkEn && !regRd) |=> regRdData == 32'h0)
        else $error("read data held past one cycle");
    a_burst_readback: assert property (p_burst_back)
        else $error("burst length readback wrong");
    a_sof_raises_irq: assert property (
        clkEn && usbEvents.sof && maskReg[BIT_SOF] && !regWr && !usbEvents.busReset
        |=> interruptOut) else $error("frame event did not raise interrupt");
    a_clear_all_quiet: assert property (
        clkEn && regWr && regAddr == STATUS_OFFSET && regWrData == STATUS_VALID
        && usbEvents == 22'h0 && !maskReg[BIT_PSEUDO_FRAME_TICK_FLAG] && $stable(dmaReason)
        && $stable(highSpeed) |=> !interruptOut) else $error("clear left interrupt high");
    a_mask_holds_low: assert property (
        clkEn && !regWr && maskReg == 32'h0 |=> !interruptOut)
        else $error("interrupt high with all sources masked");
    a_pace_rise: assert property (
        clkEn && dmaPending && !dmaRequest && !usbEvents.busReset |=> dmaRequest)
        else $error("dma request not raised");
    a_no_early_drop: assert property (
        clkEn && dmaRequest && dmaPending && !dmaCycleDone && !usbEvents.busReset
        |=> dmaRequest) else $error("dma request dropped without a cycle");
    a_drop_every_cycle: assert property (
        clkEn && dmaRequest && dmaCycleDone
        && burstReg == (busWide32 ? BYTES_BUS32 : BYTES_BUS16) |=> !dmaRequest)
        else $error("dma request kept after single cycle burst");

    // main scenarios reached
    c_burst_drop: cover property (clkEn && dmaRequest && dmaCycleDone);
    c_bus_reset: cover property (clkEn && usbEvents.busReset);
    c_irq_clear: cover property (interruptOut && regWr && regAddr == STATUS_OFFSET);
endmodule

bind peripheral_irq_and_dma_burst irq_dma_chk #(.PSEUDO_FRAME_TICK_FLAG_FS_COUNT(PSEUDO_FRAME_TICK_FLAG_FS_COUNT)) i_irq_dma_chk (
    .clk, .rst_n, .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .usbEvents,
    .highSpeed, .dmaReason, .dmaPending, .dmaCycleDone, .busWide32, .dmaRequest,
    .interruptOut);

// ### tb/dma_host_model.sv
// external dma controller that runs one bus cycle per request slot
`timescale 1ns/10ps
module dma_host_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       dmaRequest,
    input  wire logic [1:0] gap,
    output logic            dmaCycleDone
);
    logic [1:0] waitCnt;

    // answer a raised request after gap idle cycles, back to back when gap is zero
    always @(posedge clk) begin
        if (!rst_n) begin
            dmaCycleDone <= 1'b0;
            waitCnt      <= 2'h0;
        end else if (dmaRequest && waitCnt == 2'h0) begin
            dmaCycleDone <= 1'b1;
            waitCnt      <= gap;
        end else begin
            dmaCycleDone <= 1'b0;
            if (waitCnt != 2'h0) waitCnt <= waitCnt - 2'h1;
        end
    end
endmodule

// ### tb/peripheral_irq_and_dma_burst_test.sv
// self-checking bench for the interrupt status and dma burst block
`timescale 1ns/10ps
module peripheral_irq_and_dma_burst_test
    import irq_dma_pkg::*;
;
    localparam logic [15:0] FS_COUNT = 16'h0028;
    localparam logic [31:0] ALL      = 32'hffffffff;
    localparam logic [31:0] NO_TICK  = 32'hfffffffb;
    logic        clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0, highSpeed = 1'b0;
    logic        rst_n = 1'b0, dmaPending = 1'b0, busWide32 = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWrData = 32'h0;
    logic [15:0] dmaReason = 16'h0;
    logic [1:0]  gap = 2'h0;
    usb_events_t usbEvents = 22'h0;
    logic        clk, dmaCycleDone, dmaRequest, interruptOut;
    logic [31:0] regRdData;
    int          miscompares = 0, n_checks = 0, cyc = 0, i, n, k;

    peripheral_irq_and_dma_burst #(.PSEUDO_FRAME_TICK_FLAG_FS_COUNT(FS_COUNT)) i_peripheral_irq_and_dma_burst (
        .clk, .rst_n, .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .usbEvents,
        .highSpeed, .dmaReason, .dmaPending, .dmaCycleDone, .busWide32, .dmaRequest,
        .interruptOut);
    dma_host_model i_dma_host_model (.clk, .rst_n, .dmaRequest, .gap, .dmaCycleDone);

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////
    // status bit expected for event k of the packed event carrier
    function automatic logic [31:0] evBit(input int k);
        if (k < 6) return 32'h1 << (k < 2 ? k : (k < 4 ? k + 1 : k + 3));
        if (k < 14) return 32'h1 << (10 + 2 * (k - 6));
        return 32'h1 << (11 + 2 * (k - 14));
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    // read and compare the bits selected by m
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdData & m, exp);
        @(posedge clk);
    endtask

    task automatic pulse(input usb_events_t e);
        usbEvents <= e;
        @(posedge clk);
        usbEvents <= 22'h0;
        @(posedge clk);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end

    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(BURST_OFFSET, ALL, 32'h4);
        rdchk(MASK_OFFSET, ALL, MASK_RESET);
        rdchk(12'h270, ALL, 32'h0);
        wr(BURST_OFFSET, 32'h00001ffc);
        rdchk(BURST_OFFSET, ALL, 32'h1ffc);
        $display("reset and burst test done");
        wr(MASK_OFFSET, MASK_RESET & NO_TICK);
        for (i = 0; i < 22; i++) begin
            pulse(usb_events_t'(22'h1 << i));
            chk({31'h0, interruptOut}, 32'h1);
            rdchk(STATUS_OFFSET, NO_TICK, evBit(i));
            wr(STATUS_OFFSET, STATUS_VALID);
            chk({31'h0, interruptOut}, 32'h0);
        end
        pulse(usb_events_t'(22'h2));
        wr(STATUS_OFFSET, 32'h0);
        clkEn <= 1'b0;
        pulse(usb_events_t'(22'h4));
        clkEn <= 1'b1;
        rdchk(STATUS_OFFSET, NO_TICK, 32'h2);
        wr(MASK_OFFSET, 32'h0);
        @(posedge clk);
        chk({31'h0, interruptOut}, 32'h0);
        wr(MASK_OFFSET, MASK_RESET);
        $display("event and clear test done");
        dmaReason <= 16'h0100;
        highSpeed <= 1'b1;
        repeat (2) @(posedge clk);
        rdchk(STATUS_OFFSET, NO_TICK, 32'h62);
        dmaReason <= 16'h0000;
        highSpeed <= 1'b0;
        repeat (2) @(posedge clk);
        wr(STATUS_OFFSET, 32'h62);
        rdchk(STATUS_OFFSET, NO_TICK, 32'h0);
        $display("dma summary and speed test done");
        wr(STATUS_OFFSET, STATUS_VALID);
        repeat (FS_COUNT + 2) @(posedge clk);
        rdchk(STATUS_OFFSET, 32'h4, 32'h4);
        highSpeed <= 1'b1;
        wr(STATUS_OFFSET, STATUS_VALID);
        repeat (PSEUDO_FRAME_TICK_FLAG_HS_CYCLES + 2) @(posedge clk);
        rdchk(STATUS_OFFSET, 32'h4, 32'h4);
        $display("pseudo tick test done");
        wr(BURST_OFFSET, 32'h8);
        pulse(usb_events_t'(22'h200002));
        pulse(usb_events_t'(22'h1));
        rdchk(STATUS_OFFSET, NO_TICK, 32'h1);
        rdchk(BURST_OFFSET, ALL, 32'h4);
        rdchk(MASK_OFFSET, ALL, MASK_RESET);
        $display("bus reset test done");
        for (i = 0; i < 4; i++) begin
            busWide32 <= i[1];
            gap       <= {1'b0, i[0] ^ i[1]};
            wr(BURST_OFFSET, (i[1] ? 32'h4 : 32'h2) << (2 * i[0]));
            dmaPending <= 1'b1;
            n = 0;
            k = 0;
            repeat (100) begin
                @(posedge clk);
                if (dmaRequest && dmaCycleDone) n++;
                if (dmaRequest) k = 1;
                else if (k == 1) break;
            end
            chk(n, i[0] ? 32'h4 : 32'h1);
            @(posedge clk);
            chk({31'h0, dmaRequest}, 32'h1);
            dmaPending <= 1'b0;
            repeat (3) @(posedge clk);
        end
        $display("dma pacing test done");
        test_done();
    end
endmodule
